/* File: common/storm_pkg.sv */
package storm_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] CORE_TICK_CFG_OFS = 8'h00;
    localparam logic [7:0] CORE_TICK_SEL_OFS = 8'h04;
    localparam logic [7:0] TS_TICK_CFG_OFS   = 8'h08;
    localparam logic [7:0] TS_TICK_SEL_OFS   = 8'h0C;
    localparam logic [7:0] BUCKET_INDEX_OFS  = 8'h10;
    localparam logic [7:0] BUCKET_RATE_OFS   = 8'h14;
    localparam logic [7:0] BUCKET_LIMIT_OFS  = 8'h18;
    localparam logic [7:0] BUCKET_LEVEL_OFS  = 8'h1C;
    localparam logic [7:0] DROP_COUNT_OFS    = 8'h20;
    localparam logic [7:0] MC_HANDLING_OFS   = 8'h24;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int TICK_MASTER_LSB = 0;
    localparam int TICK_STAGE_LSB  = 16;
    localparam int RATE_TOKENS_LSB = 0;
    localparam int RATE_TICK_LSB   = 16;
    localparam int RATE_PKT_BIT    = 19;
    localparam int RATE_EN_BIT     = 20;
    localparam int RATE_GAP_LSB    = 24;
    localparam int LIMIT_CAP_LSB   = 0;
    localparam int LIMIT_THR_LSB   = 16;
    localparam int NUM_TICKS       = 5;

    // ------------------------------------------------------------
    // input selects and traffic types
    // ------------------------------------------------------------
    localparam logic [1:0] CORE_SEL_CLK = 2'h0;
    localparam logic [1:0] CORE_SEL_OFF = 2'h1;
    localparam logic [1:0] CORE_SEL_DBG = 2'h2;
    localparam logic [1:0] TS_SEL_OFF   = 2'h0;
    localparam logic [1:0] TS_SEL_CLK   = 2'h1;
    localparam logic [1:0] TS_SEL_DBG   = 2'h2;

    typedef enum logic [1:0] {
        TYPE_BCAST,
        TYPE_UNK_MC,
        TYPE_UNK_UC,
        TYPE_KNOWN_MC
    } traffic_t;

    // ------------------------------------------------------------
    // reset values: 1 MHz master tick at 250 MHz, decade steps,
    // buckets at 5 % of 64-byte rate on a 5 Gb/s port
    // ------------------------------------------------------------
    localparam logic [15:0] MASTER_DIV_RST = 16'h00FA;
    localparam logic [7:0]  STAGE_DIV_RST  = 8'h0A;
    localparam logic [15:0] TOKENS_RST     = 16'h0025;
    localparam logic [2:0]  TICK_SEL_RST   = 3'h2;
    localparam logic [7:0]  GAP_RST        = 8'h14;
    localparam logic [15:0] CAP_RST        = 16'h02E4;
    localparam logic [15:0] THR_RST        = 16'h0172;
    localparam logic        PKT_MODE_RST   = 1'b1;
    localparam logic        BUCKET_EN_RST  = 1'b1;
    localparam logic        MC_INCL_RST    = 1'b1;

endpackage

/* File: rtl/storm_control_token_buckets.sv */
`timescale 1ns/1ps

module tick_chain (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        in_pulse,
    input  wire logic        restart,
    input  wire logic [15:0] master_div,
    input  wire logic [7:0]  stage_div,
    output logic      [4:0]  tick_reg
);
    logic [15:0] cnt_reg [5];

    for (genvar k = 0; k < 5; k++) begin : g_stage
        logic        src;
        logic [15:0] lim;
        assign src = (k == 0) ? in_pulse : tick_reg[k-1];
        assign lim = (k == 0) ? master_div : {8'h00, stage_div};

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                cnt_reg[k]  <= 16'h0000;
                tick_reg[k] <= 1'b0;
            end else if (restart) begin
                cnt_reg[k]  <= 16'h0000;
                tick_reg[k] <= 1'b0;
            end else if (src && (cnt_reg[k] + 16'h0001 >= lim)) begin
                cnt_reg[k]  <= 16'h0000;
                tick_reg[k] <= 1'b1;
            end else begin
                cnt_reg[k]  <= src ? cnt_reg[k] + 16'h0001 : cnt_reg[k];
                tick_reg[k] <= 1'b0;
            end
        end
    end
endmodule

module storm_control_token_buckets
    import storm_pkg::*;
#(
    parameter int NUM_PORTS = 24
) (
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [1:0]                    debug_in,
    input  wire logic                          pkt_valid,
    input  wire logic [$clog2(NUM_PORTS)-1:0]  pkt_port,
    input  wire logic [47:0]                   pkt_da,
    input  wire logic                          pkt_l2_switched,
    input  wire logic                          pkt_da_known,
    input  wire logic                          pkt_mc_exclude,
    input  wire logic [15:0]                   pkt_len,
    output logic                               verdict_valid,
    output logic                               verdict_drop,
    output logic [$clog2(NUM_PORTS)-1:0]       verdict_port,
    output logic [1:0]                         verdict_type,
    output logic [4:0]                         core_tick,
    output logic [4:0]                         ts_tick
);
    localparam int PW = $clog2(NUM_PORTS);
    localparam int NB = NUM_PORTS * 4;
    localparam int IW = PW + 2;

    if (NUM_PORTS < 2 || NUM_PORTS > 64) begin : g_check
        $error("NUM_PORTS out of range");
    end

    // ------------------------------------------------------------
    // apb slave: two-cycle access phase, ready from a flop
    // ------------------------------------------------------------
    logic        acc, wr_en, hit_map;
    logic [15:0] core_master_reg;
    logic [7:0]  core_stage_reg;
    logic [1:0]  core_sel_reg;
    logic [15:0] ts_master_reg;
    logic [7:0]  ts_stage_reg;
    logic [1:0]  ts_sel_reg;
    logic [IW-1:0] index_reg;
    logic        mc_incl_reg;
    logic [31:0] drop_count_reg;
    logic        core_restart, ts_restart, cap_wr, rate_wr, idx_ok;

    logic        en_reg  [NB];
    logic        pkt_reg [NB];
    logic [2:0]  tsel_reg[NB];
    logic [15:0] tok_reg [NB];
    logic [7:0]  gap_reg [NB];
    logic [15:0] cap_reg [NB];
    logic [15:0] thr_reg [NB];
    logic [15:0] level_w [NB];

    assign acc     = psel && penable;
    assign wr_en   = acc && pready && pwrite;
    assign hit_map = (paddr <= MC_HANDLING_OFS) && (paddr[1:0] == 2'h0);
    assign core_restart = wr_en && (paddr == CORE_TICK_CFG_OFS);
    assign ts_restart   = wr_en && (paddr == TS_TICK_CFG_OFS);
    // indexed window: out-of-range bucket indices simply store nothing
    // compared at 32 bits: with 64 ports the bucket count does not fit the index width
    assign idx_ok  = (32'(index_reg) < NB);
    assign rate_wr = wr_en && (paddr == BUCKET_RATE_OFS) && idx_ok;
    assign cap_wr  = wr_en && (paddr == BUCKET_LIMIT_OFS) && idx_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc && !pready;
            pslverr <= acc && !pready && !hit_map;
            prdata  <= 32'h0000_0000;
            if (acc && !pready && !pwrite) begin
                unique case (paddr)
                    CORE_TICK_CFG_OFS: prdata <= {8'h00, core_stage_reg, core_master_reg};
                    CORE_TICK_SEL_OFS: prdata <= {30'h0, core_sel_reg};
                    TS_TICK_CFG_OFS:   prdata <= {8'h00, ts_stage_reg, ts_master_reg};
                    TS_TICK_SEL_OFS:   prdata <= {30'h0, ts_sel_reg};
                    BUCKET_INDEX_OFS:  prdata <= 32'(index_reg);
                    BUCKET_RATE_OFS:   if (idx_ok) begin
                        prdata <= {gap_reg[index_reg], 3'h0, en_reg[index_reg],
                                   pkt_reg[index_reg], tsel_reg[index_reg], tok_reg[index_reg]};
                    end
                    BUCKET_LIMIT_OFS:  if (idx_ok)
                        prdata <= {thr_reg[index_reg], cap_reg[index_reg]};
                    BUCKET_LEVEL_OFS:  if (idx_ok) prdata <= {16'h0000, level_w[index_reg]};
                    DROP_COUNT_OFS:    prdata <= drop_count_reg;
                    MC_HANDLING_OFS:   prdata <= {31'h0, mc_incl_reg};
                    default:           prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_master_reg <= MASTER_DIV_RST;
            core_stage_reg  <= STAGE_DIV_RST;
            core_sel_reg    <= CORE_SEL_CLK;
            ts_master_reg   <= MASTER_DIV_RST;
            ts_stage_reg    <= STAGE_DIV_RST;
            ts_sel_reg      <= TS_SEL_OFF;
            index_reg       <= '0;
            mc_incl_reg     <= MC_INCL_RST;
        end else if (wr_en) begin
            unique case (paddr)
                CORE_TICK_CFG_OFS: begin
                    core_master_reg <= pwdata[TICK_MASTER_LSB +: 16];
                    core_stage_reg  <= pwdata[TICK_STAGE_LSB +: 8];
                end
                CORE_TICK_SEL_OFS: core_sel_reg <= pwdata[1:0];
                TS_TICK_CFG_OFS: begin
                    ts_master_reg <= pwdata[TICK_MASTER_LSB +: 16];
                    ts_stage_reg  <= pwdata[TICK_STAGE_LSB +: 8];
                end
                TS_TICK_SEL_OFS:   ts_sel_reg  <= pwdata[1:0];
                BUCKET_INDEX_OFS:  index_reg   <= pwdata[IW-1:0];
                MC_HANDLING_OFS:   mc_incl_reg <= pwdata[0];
                default: ;
            endcase
        end
    end

    // per-bucket configuration, written through the index window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int b = 0; b < NB; b++) begin
                en_reg[b]   <= BUCKET_EN_RST;
                pkt_reg[b]  <= PKT_MODE_RST;
                tsel_reg[b] <= TICK_SEL_RST;
                tok_reg[b]  <= TOKENS_RST;
                gap_reg[b]  <= GAP_RST;
                cap_reg[b]  <= CAP_RST;
                thr_reg[b]  <= THR_RST;
            end
        end else begin
            if (rate_wr) begin
                en_reg[index_reg]   <= pwdata[RATE_EN_BIT];
                pkt_reg[index_reg]  <= pwdata[RATE_PKT_BIT];
                tsel_reg[index_reg] <= pwdata[RATE_TICK_LSB +: 3];
                tok_reg[index_reg]  <= pwdata[RATE_TOKENS_LSB +: 16];
                gap_reg[index_reg]  <= pwdata[RATE_GAP_LSB +: 8];
            end
            if (cap_wr) begin
                cap_reg[index_reg] <= pwdata[LIMIT_CAP_LSB +: 16];
                thr_reg[index_reg] <= pwdata[LIMIT_THR_LSB +: 16];
            end
        end
    end

    // ------------------------------------------------------------
    // debug pins: three flops, a rise counts once 2nd and 3rd agree
    // ------------------------------------------------------------
    logic [1:0] dbg_s1_reg, dbg_s2_reg, dbg_s3_reg;
    logic [1:0] dbg_lvl_reg, dbg_rise_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dbg_s1_reg   <= 2'h0;
            dbg_s2_reg   <= 2'h0;
            dbg_s3_reg   <= 2'h0;
            dbg_lvl_reg  <= 2'h0;
            dbg_rise_reg <= 2'h0;
        end else begin
            dbg_s1_reg <= debug_in;
            dbg_s2_reg <= dbg_s1_reg;
            dbg_s3_reg <= dbg_s2_reg;
            for (int i = 0; i < 2; i++) begin
                if (dbg_s2_reg[i] == dbg_s3_reg[i]) begin
                    dbg_lvl_reg[i] <= dbg_s3_reg[i];
                end
                dbg_rise_reg[i] <= (dbg_s2_reg[i] == dbg_s3_reg[i])
                                   && dbg_s3_reg[i] && !dbg_lvl_reg[i];
            end
        end
    end

    // ------------------------------------------------------------
    // tick sets: core ticks pace the buckets, time-sync ticks go out
    // to the gate and shaper logic
    // ------------------------------------------------------------
    logic core_in, ts_in;

    always_comb begin
        unique case (core_sel_reg)
            CORE_SEL_CLK: core_in = 1'b1;
            CORE_SEL_DBG: core_in = dbg_rise_reg[0];
            default:      core_in = 1'b0;
        endcase
        unique case (ts_sel_reg)
            TS_SEL_CLK: ts_in = 1'b1;
            TS_SEL_DBG: ts_in = dbg_rise_reg[1];
            default:    ts_in = 1'b0;
        endcase
    end

    tick_chain u_core_ticks (
        .pclk       (pclk),
        .presetn    (presetn),
        .in_pulse   (core_in),
        .restart    (core_restart),
        .master_div (core_master_reg),
        .stage_div  (core_stage_reg),
        .tick_reg   (core_tick)
    );

    tick_chain u_ts_ticks (
        .pclk       (pclk),
        .presetn    (presetn),
        .in_pulse   (ts_in),
        .restart    (ts_restart),
        .master_div (ts_master_reg),
        .stage_div  (ts_stage_reg),
        .tick_reg   (ts_tick)
    );

    // ------------------------------------------------------------
    // classification
    // ------------------------------------------------------------
    traffic_t      ptype;
    logic [IW-1:0] pidx;
    logic          pmatch, judged, drop;

    always_comb begin
        ptype  = TYPE_BCAST;
        pmatch = 1'b0;
        if (pkt_da == 48'hFFFF_FFFF_FFFF) begin
            ptype  = TYPE_BCAST;
            pmatch = 1'b1;
        end else if (pkt_l2_switched && !pkt_da_known) begin
            ptype  = pkt_da[40] ? TYPE_UNK_MC : TYPE_UNK_UC;
            pmatch = 1'b1;
        end else if (pkt_l2_switched && pkt_da[40]) begin
            ptype  = TYPE_KNOWN_MC;
            pmatch = mc_incl_reg || !pkt_mc_exclude;
        end
    end

    assign pidx   = {pkt_port, 2'(ptype)};
    assign judged = pkt_valid && pmatch && (32'(pkt_port) < NUM_PORTS);
    // only this port's own bucket decides; other copies are judged apart
    assign drop   = judged && en_reg[pidx] && (level_w[pidx] < thr_reg[pidx]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            verdict_valid  <= 1'b0;
            verdict_drop   <= 1'b0;
            verdict_port   <= '0;
            verdict_type   <= 2'h0;
            drop_count_reg <= 32'h0000_0000;
        end else begin
            verdict_valid <= pkt_valid;
            verdict_drop  <= drop;
            verdict_port  <= pkt_port;
            verdict_type  <= 2'(ptype);
            if (drop) begin
                drop_count_reg <= drop_count_reg + 32'h0000_0001;
            end
        end
    end

    // ------------------------------------------------------------
    // token buckets
    // ------------------------------------------------------------
    for (genvar b = 0; b < NB; b++) begin : g_bkt
        logic [15:0] level_reg;
        logic [16:0] sum, capped, cost;
        logic        inj, take;

        assign inj  = core_tick[(tsel_reg[b] > 3'h4) ? 3'h4 : tsel_reg[b]];
        // every matching instance on an enabled bucket is charged, dropped or not
        assign take = judged && (pidx == IW'(b)) && en_reg[b];

        always_comb begin
            sum    = {1'b0, level_reg} + (inj ? {1'b0, tok_reg[b]} : 17'h00000);
            capped = (sum > {1'b0, cap_reg[b]}) ? {1'b0, cap_reg[b]} : sum;
            cost   = pkt_reg[b] ? 17'h00001
                                : {1'b0, pkt_len} + {9'h000, gap_reg[b]};
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                level_reg <= CAP_RST;
            end else if (take) begin
                level_reg <= (capped > cost) ? 16'(capped - cost) : 16'h0000;
            end else begin
                level_reg <= 16'(capped);
            end
        end

        assign level_w[b] = level_reg;

        level_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
            !$past(cap_wr) |-> level_reg <= cap_reg[b])
            else $error("bucket level above capacity");
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    drop_below_thr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (judged && en_reg[pidx] && level_w[pidx] < thr_reg[pidx]) |=> verdict_drop)
        else $error("low bucket did not drop");
    accept_at_thr_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pkt_valid && level_w[pidx] >= thr_reg[pidx]) |=> !verdict_drop)
        else $error("bucket at threshold dropped");
    drop_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        verdict_drop |-> drop_count_reg == $past(drop_count_reg) + 32'h0000_0001)
        else $error("drop counter did not step");
    ts_input_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ts_sel_reg == TS_SEL_OFF) [*2] |=> !ts_tick[0])
        else $error("time-sync tick with input off");
    // a restart or a source change just after a tick legitimately delays the next one
    core_tick_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
        (core_tick[0] && core_sel_reg == CORE_SEL_CLK && core_master_reg == 16'h0002
         && !core_restart) |=> !core_tick[0] ##1 (core_tick[0] || $past(core_restart)
         || $past(core_sel_reg) != CORE_SEL_CLK))
        else $error("master tick period wrong");
    bcast_class_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pkt_valid && pkt_da == 48'hFFFF_FFFF_FFFF) |=> verdict_type == 2'(TYPE_BCAST))
        else $error("broadcast misclassified");
    unk_uc_class_a: assert property (@(posedge pclk) disable iff (!presetn)
        (pkt_valid && pkt_l2_switched && !pkt_da_known && !pkt_da[40])
        |=> verdict_type == 2'(TYPE_UNK_UC))
        else $error("unknown unicast misclassified");
    verdict_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        verdict_drop |-> verdict_valid && $past(pkt_port) == verdict_port)
        else $error("drop without instance");
endmodule

/* File: bench/fwd_model.sv */
`timescale 1ns/1ps
module fwd_model (
    input  wire logic        pclk,
    output logic             pkt_valid,
    output logic [4:0]       pkt_port,
    output logic [47:0]      pkt_da,
    output logic             pkt_l2_switched,
    output logic             pkt_da_known,
    output logic             pkt_mc_exclude,
    output logic [15:0]      pkt_len,
    input  wire logic [3:0]  verdict
);
    initial begin
        pkt_valid = 1'b0;
        {pkt_port, pkt_da, pkt_l2_switched, pkt_da_known, pkt_mc_exclude, pkt_len} = '0;
    end
    // released address and length are scrambled so a stale value is never mistaken for a live one
    task automatic send(input logic [4:0] p, input logic [47:0] da, input logic [2:0] f,
                        input logic [15:0] len, output logic [3:0] v);
        @(posedge pclk);
        pkt_valid <= 1'b1;
        pkt_port  <= p;
        pkt_da    <= da;
        {pkt_l2_switched, pkt_da_known, pkt_mc_exclude} <= f;
        pkt_len   <= len;
        @(posedge pclk);
        pkt_valid <= 1'b0;
        pkt_da    <= ~da;
        pkt_len   <= ~len;
        @(posedge pclk);
        v = verdict;
    endtask
endmodule

/* File: bench/test_storm_control_token_buckets.sv */
`timescale 1ns/1ps
module test_storm_control_token_buckets;
    import storm_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, d0;
    logic [1:0]  debug_in, vtype;
    logic        pvalid, pl2, pknown, pexcl, vvalid, vdrop;
    logic [4:0]  pport, vport, core_tick, ts_tick;
    logic [47:0] pda;
    logic [15:0] plen;
    logic [3:0]  v;
    int          fails, tests_run, c, t;

    storm_control_token_buckets u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .debug_in(debug_in), .pkt_valid(pvalid),
        .pkt_port(pport), .pkt_da(pda), .pkt_l2_switched(pl2), .pkt_da_known(pknown),
        .pkt_mc_exclude(pexcl), .pkt_len(plen), .verdict_valid(vvalid), .verdict_drop(vdrop),
        .verdict_port(vport), .verdict_type(vtype), .core_tick(core_tick), .ts_tick(ts_tick));
    fwd_model u_fwd (.pclk(pclk), .pkt_valid(pvalid), .pkt_port(pport), .pkt_da(pda),
        .pkt_l2_switched(pl2), .pkt_da_known(pknown), .pkt_mc_exclude(pexcl), .pkt_len(plen),
        .verdict({vvalid, vdrop, vtype}));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tmo;
        fails++;
        final_report();
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) tmo();
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask
    task automatic bk(input logic [31:0] i, input logic [31:0] r, input logic [31:0] l);
        wr(BUCKET_INDEX_OFS, i);
        wr(BUCKET_RATE_OFS, r);
        wr(BUCKET_LIMIT_OFS, l);
    endtask
    // spacing between two pulses of one tick, in core cycles
    task automatic gap(input logic ts, input int k, input int e);
        int n;
        for (int i = 0; i < 2; i++) begin
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (!(ts ? ts_tick[k] : core_tick[k]) && n < 3000);
            if (n >= 3000) tmo();
        end
        chk("tick gap", e, n);
    endtask
    task automatic tk4;
        int n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (core_tick[4] !== 1'b1 && n < 200);
        if (n >= 200) tmo();
    endtask
    task automatic cnt(input int cyc);
        c = 0;
        t = 0;
        repeat (cyc) begin
            @(posedge pclk);
            c += core_tick[0];
            t += ts_tick[0];
        end
    endtask

    task automatic t_reset;
        rdc("core cfg", CORE_TICK_CFG_OFS, 32'h000A00FA);
        rdc("core sel", CORE_TICK_SEL_OFS, 32'h0);
        rdc("ts sel", TS_TICK_SEL_OFS, 32'h0);
        wr(BUCKET_INDEX_OFS, 32'h5F);
        rdc("rate", BUCKET_RATE_OFS, 32'h141A0025);
        rdc("limit", BUCKET_LIMIT_OFS, 32'h017202E4);
        rdc("level", BUCKET_LEVEL_OFS, 32'h2E4);
        apb(1'b0, 8'h28, 32'h0);
        chk("unmapped", 1, err);
        gap(0, 0, 250);
    endtask
    task automatic t_ticks;
        cnt(300);
        chk("ts idle", 0, t);
        wr(CORE_TICK_CFG_OFS, 32'h00020005);
        gap(0, 0, 5);
        gap(0, 2, 20);
        gap(0, 4, 80);
        wr(TS_TICK_SEL_OFS, {30'h0, TS_SEL_CLK});
        wr(TS_TICK_CFG_OFS, 32'h00030004);
        gap(1, 1, 12);
        wr(CORE_TICK_SEL_OFS, {30'h0, CORE_SEL_OFF});
        @(posedge pclk);
        cnt(100);
        chk("core off", 0, c);
        chk("ts on", 25, t);
        wr(CORE_TICK_SEL_OFS, {30'h0, CORE_SEL_DBG});
        wr(TS_TICK_SEL_OFS, {30'h0, TS_SEL_DBG});
        wr(CORE_TICK_CFG_OFS, 32'h00010001);
        wr(TS_TICK_CFG_OFS, 32'h00010001);
        fork
            repeat (4) begin
                @(posedge pclk);
                debug_in <= 2'b11;
                repeat (5) @(posedge pclk);
                debug_in <= 2'b00;
                repeat (4) @(posedge pclk);
            end
            cnt(80);
        join
        chk("dbg core", 4, c);
        chk("dbg ts", 4, t);
        wr(CORE_TICK_SEL_OFS, {30'h0, CORE_SEL_CLK});
        wr(CORE_TICK_CFG_OFS, 32'h00020002);
        gap(0, 0, 2);
        wr(CORE_TICK_CFG_OFS, 32'h00020005);
    endtask
    task automatic t_storm;
        bk(32'h4, 32'h001C0000, 32'h00030005);
        apb(1'b0, DROP_COUNT_OFS, 32'h0);
        d0 = rd;
        for (int i = 0; i < 6; i++) begin
            u_fwd.send(5'd1, 48'hFFFF_FFFF_FFFF, 3'b100, 16'd64, v);
            chk("bcast", {1'b1, i > 2, 2'b00}, v);
        end
        u_fwd.send(5'd2, 48'hFFFF_FFFF_FFFF, 3'b100, 16'd64, v);
        chk("other port", 4'b1000, v);
        chk("port", 32'd2, vport);
        rdc("floor", BUCKET_LEVEL_OFS, 32'h0);
        rdc("drops", DROP_COUNT_OFS, d0 + 3);
    endtask
    task automatic t_class;
        logic [47:0] da [4] = '{48'hFFFF_FFFF_FFFF, 48'h0100_0000_0001,
                                48'h0200_0000_0001, 48'h0100_0000_0001};
        logic [2:0]  fl [4] = '{3'b100, 3'b100, 3'b100, 3'b111};
        for (int i = 0; i < 4; i++) begin
            u_fwd.send(5'd3, da[i], fl[i], 16'd64, v);
            chk("class", {2'b10, 2'(i)}, v);
        end
        wr(MC_HANDLING_OFS, 32'h0);
        u_fwd.send(5'd3, da[3], 3'b111, 16'd64, v);
        chk("excluded", 2'b10, v[3:2]);
        bk(32'd18, 32'h14140000, 32'h006403E8);
        u_fwd.send(5'd4, da[2], 3'b100, 16'd100, v);
        chk("byte ok", 4'b1010, v);
        rdc("byte level", BUCKET_LEVEL_OFS, 32'h26C);
        wr(BUCKET_RATE_OFS, 32'h14040000);
        u_fwd.send(5'd4, da[2], 3'b100, 16'd100, v);
        chk("off ok", 4'b1010, v);
        rdc("off level", BUCKET_LEVEL_OFS, 32'h26C);
    endtask
    task automatic t_refill;
        bk(32'h4, 32'h001C0007, 32'h00030064);
        tk4();
        apb(1'b0, BUCKET_LEVEL_OFS, 32'h0);
        d0 = rd;
        tk4();
        rdc("refill", BUCKET_LEVEL_OFS, d0 + 7);
        wr(BUCKET_LIMIT_OFS, 32'h0003000A);
        tk4();
        rdc("cap", BUCKET_LEVEL_OFS, 32'hA);
    endtask

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata, debug_in} = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_ticks();
        t_storm();
        t_class();
        t_refill();
        final_report();
    end
endmodule
